// [aem_alarm_monitor.sv]
// Engine alarm monitor: delayed threshold faults, latches, relay and trip
module aem_alarm_monitor #(
	parameter int SPD_W = 16,
	parameter int PCT_W = 8,
	parameter int DLY_W = 8,
	parameter int TICKS_PER_SEC = 1
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic [PCT_W-1:0] fuel_demand_pct,
	input wire logic [SPD_W-1:0] engine_speed_rpm,
	input wire logic [SPD_W-1:0] torsional_level_rpm,
	input wire logic [SPD_W-1:0] load_kw,
	input wire logic [SPD_W-1:0] rated_rpm,
	input wire logic [PCT_W-1:0] fuel_demand_limit,
	input wire logic [DLY_W-1:0] fuel_demand_delay_s,
	input wire logic [SPD_W-1:0] overspeed_limit_rpm,
	input wire logic [DLY_W-1:0] overspeed_delay_s,
	input wire logic [PCT_W-1:0] torsional_limit_pct,
	input wire logic [PCT_W-1:0] torsional_full_scale_pct,
	input wire logic torsional_scale_load,
	input wire logic [DLY_W-1:0] torsional_delay_s,
	input wire logic [SPD_W-1:0] load_limit,
	input wire logic [DLY_W-1:0] load_delay_s,
	input wire logic [SPD_W-1:0] speed_switch_on_level,
	input wire logic [SPD_W-1:0] speed_switch_off_level,
	input wire logic speed_switch_to_relay,
	input wire logic [aem_pkg::N_FAULTS-1:0] alarm_enable,
	input wire logic [aem_pkg::N_FAULTS-1:0] shutdown_enable,
	input wire logic energize_for_alarm,
	input wire logic actuator_trip_on_alarm,
	input wire logic actuator_trip_on_shutdown,
	input wire logic alarm_reset,
	output logic [aem_pkg::N_FAULTS-1:0] alarm_latched_q,
	output logic [aem_pkg::N_FAULTS-1:0] shutdown_latched_q,
	output logic [2:0] first_alarm_q,
	output logic [2:0] first_shutdown_q,
	output logic speed_switch_q,
	output logic alarm_relay_q,
	output logic actuator_trip_q,
	output logic [PCT_W-1:0] torsional_scale_q
);
	localparam int PROD_W = 2 * PCT_W + SPD_W + 2;

	logic rst_meta_q;
	logic rst_n;
	logic [aem_pkg::N_FAULTS-1:0] cond;
	logic [aem_pkg::N_FAULTS-1:0] expired;
	logic [aem_pkg::N_FAULTS-1:0] alarm_d;
	logic [aem_pkg::N_FAULTS-1:0] shutdown_d;
	logic [aem_pkg::N_FAULTS-1:0] clear_ok;
	logic [PROD_W-1:0] tors_lhs;
	logic [PROD_W-1:0] tors_rhs;
	logic reset_prev_q;
	logic reset_pulse;
	logic alarm_any;
	logic shutdown_any;

	// Lowest latched index, coded 1..N; lowest index wins a tie
	function automatic logic [2:0] first_index(input logic [aem_pkg::N_FAULTS-1:0] v);
		logic [2:0] r;
		r = aem_pkg::FIRST_NONE;
		for (int i = aem_pkg::N_FAULTS - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i + 1);
			end
		end
		return r;
	endfunction

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// Torsional scale setting, held until software reloads it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			torsional_scale_q <= aem_pkg::TORSIONAL_FULL_SCALE_PCT_RESET_PCT;
		end else if (torsional_scale_load) begin
			torsional_scale_q <= torsional_full_scale_pct;
		end
	end

	// Torsion compare without division: level*100*100 >= limit*scale*rated
	assign tors_lhs = PROD_W'(torsional_level_rpm) * PROD_W'(aem_pkg::PCT_FULL)
		* PROD_W'(aem_pkg::PCT_FULL);
	assign tors_rhs = PROD_W'(torsional_limit_pct) * PROD_W'(torsional_scale_q)
		* PROD_W'(rated_rpm);

	// Raw threshold conditions
	assign cond[aem_pkg::IDX_FUEL] = fuel_demand_pct > fuel_demand_limit;
	assign cond[aem_pkg::IDX_OVERSPEED] = engine_speed_rpm > overspeed_limit_rpm;
	assign cond[aem_pkg::IDX_TORSION] = tors_lhs >= tors_rhs;
	assign cond[aem_pkg::IDX_LOAD] = load_kw > load_limit;

	// Persistence timers, one per fault
	aem_delay_timer #(.DLY_W(DLY_W), .CNT_W(24), .TICKS_PER_SEC(TICKS_PER_SEC)) u_fuel_tmr (
		.clk(ref_clk),
		.rst_n(rst_n),
		.tick(tick),
		.cond(cond[aem_pkg::IDX_FUEL]),
		.delay_s(fuel_demand_delay_s),
		.expired_q(expired[aem_pkg::IDX_FUEL])
	);
	aem_delay_timer #(.DLY_W(DLY_W), .CNT_W(24), .TICKS_PER_SEC(TICKS_PER_SEC)) u_speed_tmr (
		.clk(ref_clk),
		.rst_n(rst_n),
		.tick(tick),
		.cond(cond[aem_pkg::IDX_OVERSPEED]),
		.delay_s(overspeed_delay_s),
		.expired_q(expired[aem_pkg::IDX_OVERSPEED])
	);
	aem_delay_timer #(.DLY_W(DLY_W), .CNT_W(24), .TICKS_PER_SEC(TICKS_PER_SEC)) u_tors_tmr (
		.clk(ref_clk),
		.rst_n(rst_n),
		.tick(tick),
		.cond(cond[aem_pkg::IDX_TORSION]),
		.delay_s(torsional_delay_s),
		.expired_q(expired[aem_pkg::IDX_TORSION])
	);
	aem_delay_timer #(.DLY_W(DLY_W), .CNT_W(24), .TICKS_PER_SEC(TICKS_PER_SEC)) u_load_tmr (
		.clk(ref_clk),
		.rst_n(rst_n),
		.tick(tick),
		.cond(cond[aem_pkg::IDX_LOAD]),
		.delay_s(load_delay_s),
		.expired_q(expired[aem_pkg::IDX_LOAD])
	);

	// Speed switch is non-latching and bypasses the fault latches
	aem_speed_switch #(.SPD_W(SPD_W)) u_speed_sw (
		.clk(ref_clk),
		.rst_n(rst_n),
		.speed(engine_speed_rpm),
		.on_level(speed_switch_on_level),
		.off_level(speed_switch_off_level),
		.switch_q(speed_switch_q)
	);

	// Reset request is the falling edge of the reset control
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_prev_q <= 1'b0;
		end else begin
			reset_prev_q <= alarm_reset;
		end
	end
	assign reset_pulse = reset_prev_q && !alarm_reset;
	assign clear_ok = reset_pulse ? ~cond : '0;

	// Latch update; a new set wins over a clear in the same cycle
	assign alarm_d = (expired & alarm_enable) | (alarm_latched_q & ~clear_ok);
	assign shutdown_d = (expired & shutdown_enable) | (shutdown_latched_q & ~clear_ok);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_latched_q <= aem_pkg::LATCH_RESET;
			shutdown_latched_q <= aem_pkg::LATCH_RESET;
		end else begin
			alarm_latched_q <= alarm_d;
			shutdown_latched_q <= shutdown_d;
		end
	end

	// First fault stays frozen until every latch of its kind has cleared
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_alarm_q <= aem_pkg::FIRST_NONE;
			first_shutdown_q <= aem_pkg::FIRST_NONE;
		end else begin
			if (alarm_d == '0) begin
				first_alarm_q <= aem_pkg::FIRST_NONE;
			end else if (first_alarm_q == aem_pkg::FIRST_NONE) begin
				first_alarm_q <= first_index(alarm_d);
			end
			if (shutdown_d == '0) begin
				first_shutdown_q <= aem_pkg::FIRST_NONE;
			end else if (first_shutdown_q == aem_pkg::FIRST_NONE) begin
				first_shutdown_q <= first_index(shutdown_d);
			end
		end
	end

	// Relay demand includes the speed switch when routed to the relay
	assign alarm_any = (alarm_latched_q != '0) || (speed_switch_to_relay && speed_switch_q);
	assign shutdown_any = shutdown_latched_q != '0;

	// Relay and actuator outputs, one cycle behind the latches
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_relay_q <= 1'b0;
			actuator_trip_q <= 1'b0;
		end else begin
			alarm_relay_q <= alarm_any ? energize_for_alarm : !energize_for_alarm;
			actuator_trip_q <= (actuator_trip_on_alarm && alarm_latched_q != '0)
				|| (actuator_trip_on_shutdown && shutdown_any);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_reset_req;
		alarm_reset ##1 !alarm_reset;
	endsequence

	AST_FUEL_DELAY: assert property ($rose(alarm_latched_q[0]) |-> $past(expired[0]))
		else $error("Fuel demand alarm latched before its delay expired");
	AST_SPEED_DELAY: assert property ($rose(alarm_latched_q[1]) |-> $past(expired[1]))
		else $error("Overspeed alarm latched before its delay expired");
	AST_TORS_ZERO: assert property (
		(torsional_level_rpm == '0 && torsional_limit_pct != '0 && torsional_scale_q != '0
		&& rated_rpm != '0) |-> !cond[2])
		else $error("Torsional fault seen with zero vibration");
	AST_TORSIONAL_FULL_SCALE_PCT: assert property (torsional_scale_load |=>
		torsional_scale_q == $past(torsional_full_scale_pct))
		else $error("Torsional scale setting not loaded");
	AST_TORS_DELAY: assert property ($rose(alarm_latched_q[2]) |-> $past(expired[2]))
		else $error("Torsional alarm latched before its delay expired");
	AST_LOAD_DELAY: assert property ($rose(alarm_latched_q[3]) |-> $past(expired[3]))
		else $error("High load alarm latched before its delay expired");
	AST_RELAY_POL: assert property (alarm_latched_q != '0 |=>
		alarm_relay_q == $past(energize_for_alarm))
		else $error("Alarm relay does not follow its polarity setting");
	AST_ACT_TRIP: assert property ((alarm_latched_q != '0 && actuator_trip_on_alarm) |=>
		actuator_trip_q)
		else $error("Actuator not tripped on alarm");
	AST_ACT_RUN: assert property ((shutdown_latched_q == '0 && !actuator_trip_on_alarm) |=>
		!actuator_trip_q)
		else $error("Actuator tripped although alarms may not trip it");
	AST_DISABLED: assert property ((!alarm_enable[0] && !alarm_latched_q[0]) |=>
		!alarm_latched_q[0])
		else $error("Disabled fault raised an alarm");
	AST_HOLD: assert property ((alarm_latched_q[1] && cond[1]) |=> alarm_latched_q[1])
		else $error("Alarm cleared while its condition persists");
	AST_RESET_CLEAR: assert property ((s_reset_req ##0 (!cond[0] && !expired[0])) |=>
		!alarm_latched_q[0])
		else $error("Reset request did not clear an ended alarm");
	AST_FIRST_HOLD: assert property ((alarm_latched_q != '0 && $past(alarm_latched_q) != '0)
		|-> $stable(first_alarm_q))
		else $error("First alarm index changed while alarms were latched");
endmodule

// [aem_pkg.sv]
// Shared constants for the engine alarm monitor
package aem_pkg;
	// Number of latched, delayed faults
	localparam int N_FAULTS = 4;
	// Fault index positions in the latch vectors
	localparam int IDX_FUEL = 0;
	localparam int IDX_OVERSPEED = 1;
	localparam int IDX_TORSION = 2;
	localparam int IDX_LOAD = 3;
	// First-fault code when nothing is latched
	localparam logic [2:0] FIRST_NONE = 3'h0;
	// Full scale of a percentage setting
	localparam int PCT_FULL = 100;
	// Reset value of the torsional full-scale setting, percent of rated rpm
	localparam logic [7:0] TORSIONAL_FULL_SCALE_PCT_RESET_PCT = 8'h01;
	// Reset value of the alarm and shutdown latch vectors
	localparam logic [N_FAULTS-1:0] LATCH_RESET = 4'h0;
	// Speed switch states
	typedef enum logic [1:0] {
		AEM_SW_OFF = 2'h1,
		AEM_SW_ON = 2'h2
	} aem_switch_e;
endpackage

// [aem_delay_timer.sv]
// Persistence timer: a condition must hold for a delay before it counts
module aem_delay_timer #(
	parameter int DLY_W = 8,
	parameter int CNT_W = 24,
	parameter int TICKS_PER_SEC = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic cond,
	input wire logic [DLY_W-1:0] delay_s,
	output logic expired_q
);
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] target;

	// Delay in ticks; sized so the product cannot wrap for 8-bit delays
	assign target = CNT_W'(delay_s) * CNT_W'(TICKS_PER_SEC);

	// Tick counter, saturates at the target so it never wraps back under it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
		end else if (!cond) begin
			count_q <= '0;
		end else if (tick && count_q < target) begin
			count_q <= count_q + CNT_W'(1);
		end
	end

	// Expiry is re-qualified by the live condition to drop on the first clock edge after it ends
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			expired_q <= 1'b0;
		end else begin
			expired_q <= cond && (count_q >= target);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_TIMER_RESTART: assert property (!cond |=> count_q == '0)
		else $error("Delay timer did not restart when condition dropped");
	AST_TIMER_NO_EARLY: assert property ($rose(expired_q) |-> $past(count_q) >= $past(target))
		else $error("Delay timer expired before the delay had elapsed");
endmodule

// [aem_speed_switch.sv]
// Speed switch with pickup and dropout levels giving hysteresis
module aem_speed_switch #(
	parameter int SPD_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [SPD_W-1:0] speed,
	input wire logic [SPD_W-1:0] on_level,
	input wire logic [SPD_W-1:0] off_level,
	output logic switch_q
);
	aem_pkg::aem_switch_e state_q;
	aem_pkg::aem_switch_e state_d;
	logic low_acting;

	// Pickup below dropout means the switch acts on falling speed
	assign low_acting = on_level < off_level;

	// Next state; between the two levels the switch keeps its state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			aem_pkg::AEM_SW_OFF: begin
				if (low_acting ? (speed < on_level) : (speed > on_level)) begin
					state_d = aem_pkg::AEM_SW_ON;
				end
			end
			aem_pkg::AEM_SW_ON: begin
				if (low_acting ? (speed > off_level) : (speed < off_level)) begin
					state_d = aem_pkg::AEM_SW_OFF;
				end
			end
			default: state_d = aem_pkg::AEM_SW_OFF;
		endcase
	end

	// State register and its registered output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= aem_pkg::AEM_SW_OFF;
			switch_q <= 1'b0;
		end else begin
			state_q <= state_d;
			switch_q <= (state_d == aem_pkg::AEM_SW_ON);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_SW_LOW_ON: assert property (
		(low_acting && speed < on_level) |=> switch_q)
		else $error("Low-acting speed switch failed to turn on");
	AST_SW_HIGH_ON: assert property (
		(!low_acting && speed > on_level && !switch_q) |=> switch_q)
		else $error("High-acting speed switch failed to turn on");
	AST_SW_HIGH_OFF: assert property (
		(!low_acting && speed < off_level && switch_q) |=> !switch_q)
		else $error("High-acting speed switch failed to turn off");
endmodule

// [aem_tick_model.sv]
// Periodic control tick source standing in for the engine controller cycle
module aem_tick_model #(
	parameter int TICK_DIV = 4
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	output logic tick
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// One-cycle strobe every TICK_DIV cycles, moved on the falling edge
	always @(negedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 0;
			tick <= 1'b0;
		end else begin
			cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
			tick <= (cnt == TICK_DIV - 1);
		end
	end
endmodule

// [engine_alarm_monitor_tb.sv]
// Self-checking bench for the engine alarm monitor
module engine_alarm_monitor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst_b, tick, torsional_scale_load, energize_for_alarm;
	logic actuator_trip_on_alarm, alarm_reset, speed_switch_q, alarm_relay_q, actuator_trip_q;
	logic [7:0] fuel_demand_pct, fuel_demand_limit, torsional_limit_pct;
	logic [7:0] torsional_full_scale_pct, torsional_scale_q, scale;
	logic [15:0] engine_speed_rpm, torsional_level_rpm, load_kw, overspeed_limit_rpm, load_limit;
	logic [15:0] speed_switch_on_level, speed_switch_off_level, lo, hi;
	logic [7:0] dly [4];
	logic [15:0] thr [4];
	logic [3:0] alarm_enable, alarm_latched_q, shutdown_latched_q, shutdown_enable;
	logic actuator_trip_on_shutdown;
	logic [2:0] first_alarm_q, first_shutdown_q;
	int fail_count, num_checks, seed, i;

	aem_tick_model #(.TICK_DIV(4)) tick_src (.ref_clk(ref_clk), .rst_b(rst_b), .tick(tick));

	aem_alarm_monitor DUT (.ref_clk(ref_clk), .rst_b(rst_b), .tick(tick),
		.fuel_demand_pct(fuel_demand_pct), .engine_speed_rpm(engine_speed_rpm),
		.torsional_level_rpm(torsional_level_rpm), .load_kw(load_kw), .rated_rpm(16'h04b0),
		.fuel_demand_limit(fuel_demand_limit), .fuel_demand_delay_s(dly[0]),
		.overspeed_limit_rpm(overspeed_limit_rpm), .overspeed_delay_s(dly[1]),
		.torsional_limit_pct(torsional_limit_pct),
		.torsional_full_scale_pct(torsional_full_scale_pct),
		.torsional_scale_load(torsional_scale_load), .torsional_delay_s(dly[2]),
		.load_limit(load_limit), .load_delay_s(dly[3]),
		.speed_switch_on_level(speed_switch_on_level),
		.speed_switch_off_level(speed_switch_off_level), .speed_switch_to_relay(1'b0),
		.alarm_enable(alarm_enable), .shutdown_enable(shutdown_enable),
		.energize_for_alarm(energize_for_alarm), .actuator_trip_on_alarm(actuator_trip_on_alarm),
		.actuator_trip_on_shutdown(actuator_trip_on_shutdown), .alarm_reset(alarm_reset),
		.alarm_latched_q(alarm_latched_q), .shutdown_latched_q(shutdown_latched_q),
		.first_alarm_q(first_alarm_q), .first_shutdown_q(first_shutdown_q),
		.speed_switch_q(speed_switch_q), .alarm_relay_q(alarm_relay_q),
		.actuator_trip_q(actuator_trip_q), .torsional_scale_q(torsional_scale_q));

	// Free-running 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Compare one result, four-state exact
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge tick);
	endtask

	// Smallest level meeting limit percent of scale percent of 1200 rpm, rounded up
	function automatic logic [15:0] tors_thr(input logic [7:0] lim, input logic [7:0] sc);
		return 16'((32'(lim) * 32'(sc) * 32'd1200 + 32'd9999) / 32'd10000);
	endfunction

	// On puts a fault exactly at its trip point, off one step short of it
	task automatic set_cond(input int f, input bit on);
		logic [15:0] v;
		v = on ? thr[f] : thr[f] - 16'h0001;
		case (f)
			0: fuel_demand_pct = v[7:0];
			1: engine_speed_rpm = v;
			2: torsional_level_rpm = v;
			default: load_kw = v;
		endcase
	endtask

	// Reset request is a high level followed by a low one
	task automatic req_reset();
		alarm_reset = 1'b1;
		cyc(1);
		alarm_reset = 1'b0;
		cyc(3);
	endtask

	task automatic test_done();
		if (fail_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard well beyond the few hundred cycles the sequence needs
	initial begin
		#200000;
		fail_count++;
		test_done();
	end

	initial begin
		seed = 28267;
		fail_count = 0;
		num_checks = 0;
		rst_b = 1'b0;
		alarm_reset = 1'b0;
		torsional_scale_load = 1'b0;
		torsional_full_scale_pct = 8'h01;
		energize_for_alarm = 1'b1;
		actuator_trip_on_alarm = 1'b1;
		alarm_enable = 4'h0;
		shutdown_enable = 4'h0;
		actuator_trip_on_shutdown = 1'b0;
		speed_switch_on_level = 16'h0000;
		speed_switch_off_level = 16'h0000;
		for (int f = 0; f < 4; f++) begin
			dly[f] = 8'h00;
		end
		fuel_demand_limit = 8'(10 + $unsigned($random(seed)) % 80);
		overspeed_limit_rpm = 16'(1000 + $unsigned($random(seed)) % 500);
		torsional_limit_pct = 8'(10 + $unsigned($random(seed)) % 90);
		load_limit = 16'(100 + $unsigned($random(seed)) % 1000);
		thr[0] = {8'h00, fuel_demand_limit} + 16'h0001;
		thr[1] = overspeed_limit_rpm + 16'h0001;
		thr[2] = tors_thr(torsional_limit_pct, 8'h01);
		thr[3] = load_limit + 16'h0001;
		for (int f = 0; f < 4; f++) begin
			set_cond(f, 0);
		end
		cyc(2);
		rst_b = 1'b1;
		cyc(4);
		chk(torsional_scale_q, 16'h0001, "scale reset");
		chk(alarm_latched_q, 16'h0000, "latch reset");
		chk(first_alarm_q, 16'h0000, "first reset");
		chk(alarm_relay_q, 16'h0000, "relay idle");
		// New torsion scale moves the torsion trip point
		scale = 8'(1 + $unsigned($random(seed)) % 4);
		torsional_full_scale_pct = scale;
		torsional_scale_load = 1'b1;
		cyc(1);
		torsional_scale_load = 1'b0;
		cyc(1);
		chk(torsional_scale_q, scale, "scale load");
		thr[2] = tors_thr(torsional_limit_pct, scale);
		// Faults that are not enabled stay silent
		for (int f = 0; f < 4; f++) begin
			set_cond(f, 1);
		end
		cyc(10);
		chk(alarm_latched_q, 16'h0000, "disabled latch");
		chk(actuator_trip_q, 16'h0000, "disabled trip");
		for (int f = 0; f < 4; f++) begin
			set_cond(f, 0);
		end
		cyc(2);
		alarm_enable = 4'hf;
		// Latch faults one after another, highest index first
		for (int k = 0; k < 4; k++) begin
			i = 3 - k;
			dly[i] = 8'(1 + $unsigned($random(seed)) % 4);
			energize_for_alarm = 1'($random(seed));
			actuator_trip_on_alarm = 1'($random(seed));
			set_cond(i, 1);
			ticks(dly[i] - 1);
			chk(alarm_latched_q[i], 1'b0, "early latch");
			ticks(1);
			cyc(4);
			chk(alarm_latched_q[i], 1'b1, "latch");
			chk(first_alarm_q, 16'h0004, "first fault");
			chk(alarm_relay_q, energize_for_alarm, "relay");
			chk(actuator_trip_q, actuator_trip_on_alarm, "trip");
			chk(shutdown_latched_q, 16'h0000, "shutdown off");
			chk(first_shutdown_q, 16'h0000, "no first shutdown");
		end
		// Reset with conditions present, then held high, then partial clear
		req_reset();
		chk(alarm_latched_q, 16'h000f, "reset refused");
		set_cond(0, 0);
		set_cond(2, 0);
		alarm_reset = 1'b1;
		cyc(5);
		chk(alarm_latched_q, 16'h000f, "held reset");
		alarm_reset = 1'b0;
		cyc(3);
		chk(alarm_latched_q, 16'h000a, "partial clear");
		chk(first_alarm_q, 16'h0004, "first kept");
		set_cond(1, 0);
		set_cond(3, 0);
		req_reset();
		chk(alarm_latched_q, 16'h0000, "full clear");
		chk(first_alarm_q, 16'h0000, "first clear");
		chk(alarm_relay_q, !energize_for_alarm, "relay release");
		chk(actuator_trip_q, 16'h0000, "trip release");
		// Zero delay, then a dropout in mid-count restarts the timer
		dly[0] = 8'h00;
		set_cond(0, 1);
		cyc(3);
		chk(alarm_latched_q[0], 1'b1, "zero delay");
		set_cond(0, 0);
		req_reset();
		dly[0] = 8'h03;
		set_cond(0, 1);
		ticks(2);
		cyc(1);
		set_cond(0, 0);
		cyc(2);
		set_cond(0, 1);
		ticks(2);
		chk(alarm_latched_q[0], 1'b0, "timer restart");
		ticks(1);
		cyc(4);
		chk(alarm_latched_q[0], 1'b1, "after restart");
		set_cond(0, 0);
		req_reset();
		// Speed switch in both orientations of pickup and dropout
		alarm_enable = 4'h0;
		// Overspeed enabled as shutdown only: no alarm latch, trip via shutdown
		shutdown_enable = 4'h2;
		actuator_trip_on_shutdown = 1'b1;
		dly[1] = 8'h00;
		set_cond(1, 1);
		cyc(4);
		chk(shutdown_latched_q, 16'h0002, "shutdown latch");
		chk(first_shutdown_q, 16'h0002, "first shutdown");
		chk(alarm_latched_q, 16'h0000, "shutdown only");
		chk(actuator_trip_q, 16'h0001, "shutdown trip");
		chk(alarm_relay_q, !energize_for_alarm, "relay no alarm");
		set_cond(1, 0);
		req_reset();
		chk(shutdown_latched_q, 16'h0000, "shutdown clear");
		chk(first_shutdown_q, 16'h0000, "first shutdown clear");
		shutdown_enable = 4'h0;
		actuator_trip_on_shutdown = 1'b0;
		lo = 16'(600 + $unsigned($random(seed)) % 200);
		hi = lo + 16'(50 + $unsigned($random(seed)) % 200);
		for (int m = 0; m < 2; m++) begin
			speed_switch_on_level = m ? hi : lo;
			speed_switch_off_level = m ? lo : hi;
			engine_speed_rpm = m ? lo - 16'h0001 : hi + 16'h0001;
			cyc(2);
			chk(speed_switch_q, 1'b0, "switch off side");
			engine_speed_rpm = m ? hi + 16'h0001 : lo - 16'h0001;
			cyc(2);
			chk(speed_switch_q, 1'b1, "switch on side");
			engine_speed_rpm = (lo + hi) >> 1;
			cyc(2);
			chk(speed_switch_q, 1'b1, "switch hold on");
			engine_speed_rpm = m ? lo - 16'h0001 : hi + 16'h0001;
			cyc(2);
			chk(speed_switch_q, 1'b0, "switch drop");
			engine_speed_rpm = (lo + hi) >> 1;
			cyc(2);
			chk(speed_switch_q, 1'b0, "switch hold off");
		end
		test_done();
	end
endmodule
